//--- ssl_setpoint_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Pressure mode: target times influence fraction
// - Curve mode: fraction of span above minimum
// - Linear function passes input straight through
// - Linear-stop maps twenty to full proportionally
// - Linear-stop: below ten percent stops motor
// - Restart only above fifteen percent input
// - Table interpolates points, holds ends flat
// - Contacts two..four binary select preset
// - All open: stop or baseline by config
// - Only enabled contacts count as code bits
// - Four independent monitors run together
// - Monitors 1-3 system-wide, four local in multipump only
// - Multipump monitor four: stop, alarm-stop, warning
// - Direction: trip above or below limit
// - Release needs return past hysteresis band
// - Active monitor applies its selected action
// - No action: relay indication only
// - Optional: no trip evaluation while pump stopped
// - Trip only after held detection delay
// - Release only after held resetting delay
// - Dry running stops pump, latched
// - Dry sensor ignored for startup delay
// - Limit relay follows active monitor
module ssl_setpoint_top
   import ssl_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC // Cycles per millisecond
) (
   input  wire logic          clk,                     // System clock
   input  wire logic          rst,                     // Sync reset
   input  wire ssl_ctrl_t     ctrlMode,                // Control mode
   input  wire ssl_infl_t     inflFunc,                // Influence function
   input  wire logic [VW-1:0] inSignal,                // Influence input
   input  wire logic [VW-1:0] baselineTarget,          // Normal setpoint
   input  wire logic [VW-1:0] userMinSpeed,            // User minimum
   input  wire logic [VW-1:0] presetTarget [NPRE],     // Preset setpoints
   input  wire logic [2:0]    contactInPin,            // Contacts 2..4
   input  wire logic [2:0]    presetEn,                // Contact used for preset
   input  wire logic          allOpenStop,             // All open means stop
   input  wire logic [VW-1:0] tableX [NPTS],           // Table inputs, rising
   input  wire logic [VW-1:0] tableY [NPTS],           // Table outputs
   input  wire logic [3:0]    tableCount,              // Points used, 2..8
   input  wire logic          multiPump,               // Multipump system
   input  wire logic [VW-1:0] monValue [NMON],         // Measured values
   input  wire logic [VW-1:0] monLimit [NMON],         // Limits
   input  wire logic [VW-1:0] monHyst [NMON],          // Hysteresis bands
   input  wire logic [NMON-1:0] monBelow,              // Trip when below
   input  wire logic [NMON-1:0] monSuppress,           // Suppress in stop
   input  wire ssl_act_t      monAction [NMON],        // Actions
   input  wire logic [15:0]   monDetDelay [NMON],      // Detection delay, ms
   input  wire logic [15:0]   monRstDelay [NMON],      // Reset delay, ms
   input  wire logic          dryEnable,               // Dry-run protection on
   input  wire logic          dryRunPin,               // Dry-run sensor pin
   input  wire logic [7:0]    dryDelay,                // Dry blank, seconds
   input  wire logic          restartReq,              // Manual restart pulse
   output logic [VW-1:0]      effectiveTarget,         // Effective setpoint
   output ssl_speed_t         speedMode,               // Resulting speed mode
   output logic               motorStop,               // Motor stopped
   output logic [NMON-1:0]    limitRelay,              // Limit relays
   output logic               alarm,                   // Alarm
   output logic               warning,                 // Warning
   output logic               systemStop,              // System-wide stop
   output logic               localStop,               // Local pump stop
   output logic               dryRunStop,              // Dry-run latched
   output logic               lowInputStop             // Low-input stop
);

   // Scale a value by a fraction where all ones means one
   function automatic logic [VW-1:0] scaleFrac(input logic [VW-1:0] a, input logic [VW-1:0] f);
      logic [2*VW-1:0] p;
      p = (a * f) + {{VW{1'b0}}, a};
      return p[2*VW-1:VW];
   endfunction : scaleFrac

   // Pin synchronisers
   logic [3:0] syncA_r, syncB_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA_r <= 4'h0;
         syncB_r <= 4'h0;
      end else begin
         syncA_r <= {dryRunPin, contactInPin};
         syncB_r <= syncA_r;
      end
   end

   // Millisecond time base; seconds count from run start
   logic [15:0] tickCnt_r, tickCnt_nxt;
   logic [9:0]  msCnt_r, msCnt_nxt;
   logic        tick, secTick;
   ssl_speed_t  speed_r;
   always_comb begin
      tick        = (tickCnt_r == 16'(TICK_CYCLES - 1));
      tickCnt_nxt = tick ? 16'h0000 : tickCnt_r + 16'h0001;
      secTick     = tick && (msCnt_r == 10'(MS_PER_S - 1));
      msCnt_nxt   = (secTick || speed_r == SM_STOP) ? 10'h000 : (tick ? msCnt_r + 10'h001 : msCnt_r);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         tickCnt_r <= 16'h0000;
         msCnt_r   <= 10'h000;
      end else begin
         tickCnt_r <= tickCnt_nxt;
         msCnt_r   <= msCnt_nxt;
      end
   end

   // Preset selection from enabled contacts
   logic [2:0]    presetCode;
   logic [VW-1:0] baseSel;
   logic          presetStop;
   always_comb begin
      presetCode = syncB_r[2:0] & presetEn;
      presetStop = 1'b0;
      baseSel    = baselineTarget;
      if (presetCode == 3'h0) begin
         presetStop = allOpenStop;
      end else begin
         baseSel = presetTarget[presetCode - 3'h1];
      end
   end

   // Table lookup with linear interpolation
   logic [VW-1:0]   tableVal;
   logic [2:0]      seg;
   logic [VW:0]     dx, span, dy;
   logic [2*VW+1:0] num;
   logic            yDown;
   always_comb begin
      seg   = 3'h0;
      for (int i = 1; i < NPTS - 1; i++) begin
         if ((4'(i) < tableCount - 4'h1) && (inSignal >= tableX[i])) begin
            seg = 3'(i);
         end
      end
      dx    = {1'b0, inSignal} - {1'b0, tableX[seg]};
      span  = {1'b0, tableX[seg + 3'h1]} - {1'b0, tableX[seg]};
      yDown = (tableY[seg + 3'h1] < tableY[seg]); // Falling segment
      dy    = yDown ? ({1'b0, tableY[seg]} - {1'b0, tableY[seg + 3'h1]})
                    : ({1'b0, tableY[seg + 3'h1]} - {1'b0, tableY[seg]});
      num   = 34'(dx) * 34'(dy);
      if (inSignal <= tableX[0]) begin
         tableVal = tableY[0];
      end else if (inSignal >= tableX[tableCount[2:0] - 3'h1]) begin
         tableVal = tableY[tableCount[2:0] - 3'h1];
      end else if (span == 17'h00000) begin
         tableVal = tableY[seg];
      end else if (yDown) begin
         tableVal = VW'(34'({1'b0, tableY[seg]}) - (num / 34'(span)));
      end else begin
         tableVal = VW'(34'({1'b0, tableY[seg]}) + (num / 34'(span)));
      end
   end

   // Influence factor and effective setpoint
   logic [VW-1:0] infl, effNxt;
   logic [2*VW-1:0] lsNum;
   always_comb begin
      lsNum = 32'(inSignal - P20) * 32'(FULL);
      case (inflFunc)
         IF_LIN:   infl = inSignal;
         IF_LSTOP: infl = (inSignal < P20) ? 16'h0000 : VW'(lsNum / 32'(FULL - P20));
         IF_TABLE: infl = tableVal;
         default:  infl = FULL;
      endcase
      if (ctrlMode == CM_CURVE) begin
         effNxt = scaleFrac(baseSel - userMinSpeed, infl) + userMinSpeed;
      end else begin
         effNxt = scaleFrac(baseSel, infl);
      end
   end

   // Low-input stop with hysteresis
   logic lowStop_r, lowStop_nxt;
   always_comb begin
      lowStop_nxt = lowStop_r;
      if (inflFunc != IF_LSTOP) begin
         lowStop_nxt = 1'b0;
      end else if (inSignal < P10) begin
         lowStop_nxt = 1'b1;
      end else if (inSignal > P15) begin
         lowStop_nxt = 1'b0;
      end
   end

   // Limit monitors
   logic [NMON-1:0] monActive, monHold;
   for (genvar g = 0; g < NMON; g++) begin : gMon
      assign monHold[g] = monSuppress[g] && (speed_r == SM_STOP) && !monActive[g];
      ssl_limit_mon uMon (
         .clk      (clk),
         .rst      (rst),
         .tick     (tick),
         .value    (monValue[g]),
         .limit    (monLimit[g]),
         .hyst     (monHyst[g]),
         .below    (monBelow[g]),
         .hold     (monHold[g]),
         .detDelay (monDetDelay[g]),
         .rstDelay (monRstDelay[g]),
         .active   (monActive[g])
      );
   end

   // Action combining with fixed priority
   ssl_act_t act;
   logic anyStop, anyMin, anyMax, anyUser, alarmNxt, warnNxt, sysStopNxt, locStopNxt;
   always_comb begin
      {anyStop, anyMin, anyMax, anyUser} = 4'h0;
      {alarmNxt, warnNxt, sysStopNxt, locStopNxt} = 4'h0;
      for (int i = 0; i < NMON; i++) begin
         act = monAction[i];
         if (i == NMON - 1 && multiPump && act != AC_NONE && act != AC_STOP && act != AC_ALSTOP) begin
            act = AC_WARN;
         end
         if (monActive[i]) begin
            case (act)
               AC_STOP, AC_ALSTOP: begin
                  anyStop    = 1'b1;
                  locStopNxt = locStopNxt || (i == NMON - 1 && multiPump);
                  sysStopNxt = sysStopNxt || !(i == NMON - 1 && multiPump);
               end
               AC_MIN, AC_ALMIN:   anyMin = 1'b1;
               AC_MAX, AC_ALMAX:   anyMax = 1'b1;
               AC_USER, AC_ALUSER: anyUser = 1'b1;
               AC_WARN:            warnNxt = 1'b1;
               default:            ;
            endcase
            if (act >= AC_ALSTOP && act <= AC_ALUSER) begin
               alarmNxt = 1'b1;
            end
         end
      end
   end

   // Dry-run protection with startup blanking
   logic       dryStop_r, dryStop_nxt, armed;
   logic [7:0] upSec_r, upSec_nxt;
   always_comb begin
      armed     = (upSec_r >= dryDelay);
      upSec_nxt = upSec_r;
      if (speed_r == SM_STOP) begin
         upSec_nxt = 8'h00;
      end else if (secTick && upSec_r != 8'hff) begin
         upSec_nxt = upSec_r + 8'h01;
      end
      dryStop_nxt = dryStop_r && !restartReq;
      if (dryEnable && syncB_r[3] && armed && speed_r != SM_STOP) begin
         dryStop_nxt = 1'b1;
      end
   end

   // Speed mode resolution
   ssl_speed_t speedNxt;
   always_comb begin
      if (anyStop || dryStop_r || lowStop_r || presetStop) begin
         speedNxt = SM_STOP;
      end else if (anyMin) begin
         speedNxt = SM_MIN;
      end else if (anyMax) begin
         speedNxt = SM_MAX;
      end else if (anyUser) begin
         speedNxt = SM_USER;
      end else begin
         speedNxt = SM_NORMAL;
      end
   end

   // Output registers
   logic [VW-1:0] eff_r;
   logic alarm_r, warn_r, sysStop_r, locStop_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         eff_r     <= 16'h0000;
         speed_r   <= SM_NORMAL;
         lowStop_r <= 1'b0;
         dryStop_r <= 1'b0;
         upSec_r   <= 8'h00;
         alarm_r   <= 1'b0;
         warn_r    <= 1'b0;
         sysStop_r <= 1'b0;
         locStop_r <= 1'b0;
      end else begin
         eff_r     <= effNxt;
         speed_r   <= speedNxt;
         lowStop_r <= lowStop_nxt;
         dryStop_r <= dryStop_nxt;
         upSec_r   <= upSec_nxt;
         alarm_r   <= alarmNxt;
         warn_r    <= warnNxt;
         sysStop_r <= sysStopNxt;
         locStop_r <= locStopNxt;
      end
   end

   assign effectiveTarget = eff_r;
   assign speedMode       = speed_r;
   assign motorStop       = (speed_r == SM_STOP);
   assign limitRelay      = monActive;
   assign alarm           = alarm_r;
   assign warning         = warn_r;
   assign systemStop      = sysStop_r;
   assign localStop       = locStop_r;
   assign dryRunStop      = dryStop_r;
   assign lowInputStop    = lowStop_r;

   AST_LOW_SET: assert property (@(posedge clk) disable iff (rst)
      (inflFunc == IF_LSTOP && inSignal < P10) |=> lowStop_r ##1 (speed_r == SM_STOP))
      else $error("low input did not stop motor");
   AST_LOW_HOLD: assert property (@(posedge clk) disable iff (rst)
      (lowStop_r && inflFunc == IF_LSTOP && inSignal <= P15) |=> lowStop_r)
      else $error("low-input stop released inside band");
   AST_FULL_PASS: assert property (@(posedge clk) disable iff (rst)
      (inflFunc == IF_NONE && (syncB_r[2:0] & presetEn) == 3'h0) |=> (eff_r == $past(baselineTarget)))
      else $error("full influence changed setpoint");
   AST_PRESET_SEL: assert property (@(posedge clk) disable iff (rst)
      (syncB_r[2:0] == 3'h6 && presetEn == 3'h7 && inflFunc == IF_NONE) |=> (eff_r == $past(presetTarget[5])))
      else $error("preset six not selected");
   AST_DRY_LATCH: assert property (@(posedge clk) disable iff (rst)
      (dryStop_r && !restartReq) |=> dryStop_r)
      else $error("dry-run stop released without restart");
   AST_DRY_BLANK: assert property (@(posedge clk) disable iff (rst)
      $rose(dryStop_r) |-> $past(armed) && $past(dryEnable))
      else $error("dry-run stop inside blanking delay");
   AST_STOP_PRIO: assert property (@(posedge clk) disable iff (rst)
      (anyStop && anyMax) |=> (speed_r == SM_STOP))
      else $error("speed override beat stop");
   AST_M4_WARN: assert property (@(posedge clk) disable iff (rst)
      (multiPump && monActive[3] && monAction[3] == AC_MAX && monActive[2:0] == 3'h0) |=> warn_r && speed_r != SM_MAX)
      else $error("monitor four applied speed override");

endmodule : ssl_setpoint_top

//--- ssl_pkg.sv
package ssl_pkg;

   // Value widths and counts
   localparam int VW    = 16;
   localparam int NMON  = 4;
   localparam int NPRE  = 7;
   localparam int NPTS  = 8;

   // Fractions of full scale on a 16-bit value
   localparam logic [15:0] FULL = 16'hffff;
   localparam logic [15:0] P10  = 16'h1999;
   localparam logic [15:0] P15  = 16'h2666;
   localparam logic [15:0] P20  = 16'h3333;

   // Time base: one millisecond tick, seconds from ticks
   localparam int CLK_NS   = 20;
   localparam int TICK_NS  = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int MS_PER_S = 1000;

   // Control mode
   typedef enum logic {CM_PRESS, CM_CURVE} ssl_ctrl_t;

   // Influence function
   typedef enum logic [1:0] {IF_NONE, IF_LIN, IF_LSTOP, IF_TABLE} ssl_infl_t;

   // Monitor action
   typedef enum logic [3:0] {
      AC_NONE, AC_STOP, AC_MIN, AC_MAX, AC_USER,
      AC_ALSTOP, AC_ALMIN, AC_ALMAX, AC_ALUSER, AC_WARN
   } ssl_act_t;

   // Resulting speed mode
   typedef enum logic [2:0] {SM_NORMAL, SM_STOP, SM_MIN, SM_MAX, SM_USER} ssl_speed_t;

endpackage : ssl_pkg

//--- ssl_limit_mon.sv
`timescale 1ns/100ps
module ssl_limit_mon
   import ssl_pkg::*;
(
   input  wire logic          clk,      // System clock
   input  wire logic          rst,      // Sync reset
   input  wire logic          tick,     // Millisecond tick
   input  wire logic [VW-1:0] value,    // Measured value
   input  wire logic [VW-1:0] limit,    // Limit
   input  wire logic [VW-1:0] hyst,     // Hysteresis band
   input  wire logic          below,    // Trip when below limit
   input  wire logic          hold,     // Suspend evaluation
   input  wire logic [15:0]   detDelay, // Detection delay, ms
   input  wire logic [15:0]   rstDelay, // Resetting delay, ms
   output logic               active    // Monitor active
);

   logic        active_r, active_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic        trip, clr, want;

   // Trip and release conditions, release past limit by the band
   always_comb begin
      trip = below ? (value < limit) : (value > limit);
      clr  = below ? ({1'b0, value} > ({1'b0, limit} + {1'b0, hyst}))
                   : (({1'b0, value} + {1'b0, hyst}) < {1'b0, limit});
      want = active_r ? clr : trip;
   end

   // Delay counting toward a state change
   always_comb begin
      active_nxt = active_r;
      cnt_nxt    = cnt_r;
      if (hold) begin
         cnt_nxt = 16'h0000;
      end else if (!want) begin
         cnt_nxt = 16'h0000;
      end else if (cnt_r >= (active_r ? rstDelay : detDelay)) begin
         active_nxt = !active_r;
         cnt_nxt    = 16'h0000;
      end else if (tick) begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         active_r <= 1'b0;
         cnt_r    <= 16'h0000;
      end else begin
         active_r <= active_nxt;
         cnt_r    <= cnt_nxt;
      end
   end

   assign active = active_r;

   AST_MON_RISE: assert property (@(posedge clk) disable iff (rst)
      $rose(active_r) |-> $past(trip) && !$past(hold) && ($past(cnt_r) >= $past(detDelay)))
      else $error("monitor set without held trip");

   AST_MON_FALL: assert property (@(posedge clk) disable iff (rst)
      $fell(active_r) |-> $past(clr) && ($past(cnt_r) >= $past(rstDelay)))
      else $error("monitor cleared without release band");

endmodule : ssl_limit_mon

//--- ssl_panel_model.sv
`timescale 1ns/100ps
module ssl_panel_model (
   input  wire logic       clk,          // System clock
   input  wire logic [2:0] codeCmd,      // Contacts to close
   input  wire logic       dryCmd,       // Sensor reports dry
   input  wire logic       restartCmd,   // Operator restart level
   output logic [2:0]      contactInPin, // Contacts 2..4, closed = 1
   output logic            dryRunPin,    // Dry sensor, 1 = dry
   output logic            restartReq    // One-cycle restart pulse
);
   logic restartCmd_r;

   // Contacts and sensor follow the panel
   always_ff @(posedge clk) begin
      contactInPin <= codeCmd;
      dryRunPin    <= dryCmd;
      restartCmd_r <= restartCmd;
   end

   // Restart only on an operator action
   assign restartReq = restartCmd & ~restartCmd_r;
endmodule : ssl_panel_model

//--- tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
`define WAITUP(c, n) begin for (int w = 0; w < (n) && !(c); w++) @(negedge clk); end
module tb;
   import ssl_pkg::*;
   localparam int TK = 4;
   logic clk, rst, allOpenStop, multiPump, dryEnable, dryRunPin, restartReq, dryCmd, restartCmd;
   logic motorStop, alarm, warning, systemStop, localStop, dryRunStop, lowInputStop;
   ssl_ctrl_t ctrlMode;
   ssl_infl_t inflFunc;
   ssl_speed_t speedMode;
   ssl_act_t monAction [NMON];
   logic [VW-1:0] inSignal, baselineTarget, userMinSpeed, effectiveTarget, x;
   logic [VW-1:0] presetTarget [NPRE];
   logic [VW-1:0] tableX [NPTS];
   logic [VW-1:0] tableY [NPTS];
   logic [VW-1:0] monValue [NMON];
   logic [VW-1:0] monLimit [NMON];
   logic [VW-1:0] monHyst [NMON];
   logic [15:0] monDetDelay [NMON];
   logic [15:0] monRstDelay [NMON];
   logic [2:0] contactInPin, presetEn, codeCmd;
   logic [3:0] tableCount, monBelow, monSuppress, limitRelay;
   logic [7:0] dryDelay;
   int fail_count, num_checks, cycles;

   ssl_setpoint_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst(rst), .ctrlMode(ctrlMode), .inflFunc(inflFunc),
      .inSignal(inSignal), .baselineTarget(baselineTarget), .userMinSpeed(userMinSpeed),
      .presetTarget(presetTarget), .contactInPin(contactInPin), .presetEn(presetEn), .allOpenStop(allOpenStop),
      .tableX(tableX), .tableY(tableY), .tableCount(tableCount), .multiPump(multiPump), .monValue(monValue),
      .monLimit(monLimit), .monHyst(monHyst), .monBelow(monBelow), .monSuppress(monSuppress),
      .monAction(monAction), .monDetDelay(monDetDelay), .monRstDelay(monRstDelay), .dryEnable(dryEnable),
      .dryRunPin(dryRunPin), .dryDelay(dryDelay), .restartReq(restartReq), .effectiveTarget(effectiveTarget),
      .speedMode(speedMode), .motorStop(motorStop), .limitRelay(limitRelay), .alarm(alarm), .warning(warning),
      .systemStop(systemStop), .localStop(localStop), .dryRunStop(dryRunStop), .lowInputStop(lowInputStop));

   ssl_panel_model panel (.clk(clk), .codeCmd(codeCmd), .dryCmd(dryCmd), .restartCmd(restartCmd),
      .contactInPin(contactInPin), .dryRunPin(dryRunPin), .restartReq(restartReq));

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles > 15000) begin
         fail_count++;
         final_report();
      end
   end

   // Target scaled by a full-scale fraction
   function automatic logic [15:0] scl(input logic [15:0] b, input logic [15:0] f);
      return 16'((32'(b) * 32'(f) + 32'(b)) >> 16);
   endfunction : scl

   // Linear-with-stop influence factor
   function automatic logic [15:0] lst(input logic [15:0] v);
      return (v < P20) ? 16'h0 : 16'((32'(v - P20) * 32'hffff) / 32'(FULL - P20));
   endfunction : lst

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic final_report();
      if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // Set one monitor's settings
   task automatic mon(input int i, input logic [15:0] v, lim, h, input logic bel, input ssl_act_t a,
                      input logic [15:0] dd, rd);
      @(posedge clk);
      monValue[i] <= v; monLimit[i] <= lim; monHyst[i] <= h; monBelow[i] <= bel;
      monAction[i] <= a; monDetDelay[i] <= dd; monRstDelay[i] <= rd;
   endtask : mon

   // Main sequence
   initial begin
      rst = 1'b1; ctrlMode = CM_PRESS; inflFunc = IF_NONE; inSignal = '0; baselineTarget = 16'h4000;
      userMinSpeed = '0; presetEn = '0; allOpenStop = 1'b0; tableCount = 4'h3; multiPump = 1'b0;
      monBelow = '0; monSuppress = '0; dryEnable = 1'b0; dryDelay = '0; codeCmd = '0; dryCmd = 1'b0;
      restartCmd = 1'b0; fail_count = 0; num_checks = 0; cycles = 0;
      tableX = '{16'h1000, 16'h2000, 16'h4000, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
      tableY = '{16'h2000, 16'h6000, 16'h7000, 16'h7000, 16'h7000, 16'h7000, 16'h7000, 16'h7000};
      for (int i = 0; i < NMON; i++) begin
         monValue[i] = '0; monLimit[i] = FULL; monHyst[i] = '0; monAction[i] = AC_NONE;
         monDetDelay[i] = '0; monRstDelay[i] = '0;
      end
      void'($urandom(32'hbddb));
      for (int i = 0; i < NPRE; i++) presetTarget[i] = 16'($urandom());
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cyc(4);
      // Linear influence, both control modes with random values
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         x = 16'($urandom()); inSignal <= x; inflFunc <= IF_LIN; ctrlMode <= ssl_ctrl_t'(i[0]);
         baselineTarget <= 16'($urandom_range(16'hffff, 16'h8000)); userMinSpeed <= 16'($urandom_range(16'h7fff));
         cyc(4);
         if (i[0]) `CHK("curve", scl(baselineTarget - userMinSpeed, x) + userMinSpeed, effectiveTarget)
         else `CHK("press", scl(baselineTarget, x), effectiveTarget)
      end
      // Linear with stop: proportional part, then the stop hysteresis
      @(posedge clk);
      ctrlMode <= CM_PRESS; inflFunc <= IF_LSTOP;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         x = (i == 0) ? P20 : 16'($urandom_range(16'hffff, 16'h3333)); inSignal <= x;
         cyc(4);
         `CHK("lstop", scl(baselineTarget, lst(x)), effectiveTarget)
      end
      @(posedge clk) inSignal <= P10 - 16'h1;
      cyc(4);
      `CHK("lowstop", 1'b1, lowInputStop)
      `CHK("lowmotor", 1'b1, motorStop)
      @(posedge clk) inSignal <= P15;
      cyc(4);
      `CHK("hyststay", 1'b1, lowInputStop)
      @(posedge clk) inSignal <= P15 + 16'h1;
      cyc(4);
      `CHK("hystrel", 1'b0, lowInputStop)
      @(posedge clk) inSignal <= 16'h2000;
      cyc(4);
      `CHK("hystrun", 1'b0, lowInputStop)
      // Table: below first, on two segments, beyond last
      @(posedge clk) inflFunc <= IF_TABLE;
      foreach (tableX[i]) if (i < 4) begin
         @(posedge clk);
         inSignal <= (i == 0) ? 16'h0800 : (i == 1) ? 16'h1800 : (i == 2) ? 16'h3000 : 16'h9000;
         cyc(4);
         `CHK("table", scl(baselineTarget, (i == 0) ? 16'h2000 : (i == 1) ? 16'h4000 :
              (i == 2) ? 16'h6800 : 16'h7000), effectiveTarget)
      end
      // Preset codes through the contacts
      @(posedge clk);
      inflFunc <= IF_NONE; presetEn <= 3'b111;
      for (int c = 1; c < 8; c++) begin
         @(posedge clk) codeCmd <= 3'(c);
         cyc(6);
         `CHK("preset", presetTarget[c-1], effectiveTarget)
      end
      @(posedge clk);
      presetEn <= 3'b001; codeCmd <= 3'b110;
      cyc(6);
      `CHK("masked", baselineTarget, effectiveTarget)
      @(posedge clk) codeCmd <= 3'b111;
      cyc(6);
      `CHK("onebit", presetTarget[0], effectiveTarget)
      @(posedge clk);
      presetEn <= 3'b000; allOpenStop <= 1'b1;
      cyc(6);
      `CHK("openstop", 1'b1, motorStop)
      // Suppressed while stopped, evaluated once running
      @(posedge clk) monSuppress <= 4'b0100;
      mon(2, 16'd50, 16'd100, 16'd10, 1'b1, AC_NONE, 16'h0, 16'h0);
      cyc(10);
      `CHK("suppress", 1'b0, limitRelay[2])
      @(posedge clk) allOpenStop <= 1'b0;
      `WAITUP(limitRelay[2], 8)
      `CHK("unsupp", 1'b1, limitRelay[2])
      mon(2, 16'd500, 16'd100, 16'd10, 1'b1, AC_NONE, 16'h0, 16'h0);
      // Timed below-limit monitor, broken condition restarts the count
      mon(0, 16'd900, 16'd1000, 16'd200, 1'b1, AC_NONE, 16'h3, 16'h2);
      cyc(6);
      mon(0, 16'd1100, 16'd1000, 16'd200, 1'b1, AC_NONE, 16'h3, 16'h2);
      mon(0, 16'd900, 16'd1000, 16'd200, 1'b1, AC_NONE, 16'h3, 16'h2);
      cyc(6);
      `CHK("detrestart", 1'b0, limitRelay[0])
      `WAITUP(limitRelay[0], 30)
      `CHK("detected", 1'b1, limitRelay[0])
      `CHK("noaction", SM_NORMAL, speedMode)
      mon(0, 16'd1100, 16'd1000, 16'd200, 1'b1, AC_NONE, 16'h3, 16'h2);
      cyc(40);
      `CHK("inband", 1'b1, limitRelay[0])
      mon(0, 16'd1300, 16'd1000, 16'd200, 1'b1, AC_NONE, 16'h3, 16'h2);
      cyc(3);
      `CHK("rstdelay", 1'b1, limitRelay[0])
      `WAITUP(!limitRelay[0], 30)
      `CHK("released", 1'b0, limitRelay[0])
      // Actions, priorities and the local monitor
      mon(1, 16'd200, 16'd100, 16'd10, 1'b0, AC_MAX, 16'h0, 16'h0);
      cyc(4);
      `CHK("max", SM_MAX, speedMode)
      mon(2, 16'd200, 16'd100, 16'd10, 1'b0, AC_STOP, 16'h0, 16'h0);
      cyc(4);
      `CHK("both", 4'b0110, limitRelay)
      `CHK("prio", SM_STOP, speedMode)
      `CHK("sysstop", 1'b1, systemStop)
      mon(2, 16'd0, 16'd100, 16'd10, 1'b0, AC_STOP, 16'h0, 16'h0);
      mon(1, 16'd200, 16'd100, 16'd10, 1'b0, AC_ALMIN, 16'h0, 16'h0);
      cyc(4);
      `CHK("almin", SM_MIN, speedMode)
      `CHK("alarm", 1'b1, alarm)
      mon(1, 16'd200, 16'd100, 16'd10, 1'b0, AC_ALUSER, 16'h0, 16'h0);
      cyc(4);
      `CHK("aluser", SM_USER, speedMode)
      mon(1, 16'd0, 16'd100, 16'd10, 1'b0, AC_NONE, 16'h0, 16'h0);
      @(posedge clk) multiPump <= 1'b1;
      mon(3, 16'd200, 16'd100, 16'd10, 1'b0, AC_STOP, 16'h0, 16'h0);
      cyc(4);
      `CHK("local", 2'b01, {systemStop, localStop})
      mon(3, 16'd200, 16'd100, 16'd10, 1'b0, AC_MAX, 16'h0, 16'h0);
      cyc(4);
      `CHK("warn", 1'b1, warning)
      `CHK("m4speed", SM_NORMAL, speedMode)
      mon(3, 16'd0, 16'd100, 16'd10, 1'b0, AC_NONE, 16'h0, 16'h0);
      // Dry running: latched stop, manual restart, start-up blanking
      @(posedge clk);
      dryEnable <= 1'b1; dryCmd <= 1'b1;
      `WAITUP(dryRunStop, 20)
      cyc(1);
      `CHK("dry", 2'b11, {dryRunStop, motorStop})
      @(posedge clk) dryCmd <= 1'b0;
      cyc(20);
      `CHK("drylatch", 1'b1, dryRunStop)
      @(posedge clk) restartCmd <= 1'b1;
      @(posedge clk) restartCmd <= 1'b0;
      cyc(5);
      `CHK("restart", 1'b0, dryRunStop)
      @(posedge clk);
      dryDelay <= 8'h1; dryCmd <= 1'b1;
      cyc(3000);
      `CHK("blank", 1'b0, dryRunStop)
      `WAITUP(dryRunStop, 2000)
      `CHK("blankend", 1'b1, dryRunStop)
      final_report();
   end
endmodule : tb
